// file: hdl/tmr16_pkg.sv
// Package: constants, modes and carriers of the 16-bit timer core
package tmr16_pkg;
   localparam int unsigned CNT_W = 16;
   localparam logic [15:0] BOTTOM_VAL = 16'h0000;
   localparam logic [15:0] MAX_VAL = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] IRQ_RST = 4'h0;
   // Interrupt bit positions in flag and mask registers
   localparam int unsigned IRQ_OVF = 0;
   localparam int unsigned IRQ_MA = 1;
   localparam int unsigned IRQ_MB = 2;
   localparam int unsigned IRQ_CAP = 3;
   // control_a fields
   localparam int unsigned CA_WGM_LO = 0;
   localparam int unsigned CA_COMB_LO = 4;
   localparam int unsigned CA_COMA_LO = 6;
   // control_b fields
   localparam int unsigned CB_CS_LO = 0;
   localparam int unsigned CB_WGM_HI = 3;
   localparam int unsigned CB_CAP_EDGE = 6;
   localparam int unsigned CB_CAP_FILT = 7;
   // Noise filter depth: samples that must agree
   localparam int unsigned FILT_LEN = 4;
   // Prescaler ratios, as log2 of the divide
   localparam logic [3:0] PS_8 = 4'h3;
   localparam logic [3:0] PS_64 = 4'h6;
   localparam logic [3:0] PS_256 = 4'h8;
   localparam logic [3:0] PS_1024 = 4'ha;

   // Register selector for the 8-bit access port
   typedef enum logic [3:0] {
      REG_CNT_LO, REG_CNT_HI, REG_CMPA_LO, REG_CMPA_HI, REG_CMPB_LO, REG_CMPB_HI,
      REG_CAP_LO, REG_CAP_HI, REG_CTRL_A, REG_CTRL_B, REG_FLAG, REG_MASK
   } tmr16_reg_t;

   // One CPU byte access
   typedef struct packed {
      logic wr;
      logic rd;
      tmr16_reg_t sel;
      logic [7:0] wdata;
   } tmr16_bus_t;
endpackage

// file: hdl/tmr16_tick_gen.sv
// Tick source: prescaler taps and external pin edge detection
`timescale 1ns/100ps
`default_nettype none
module tmr16_tick_gen #(
   parameter int unsigned PS_W = 10
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [2:0] clk_sel_i,
   input wire logic ext_pin_i,
   output logic tick_o
);
   if (PS_W < 10) begin : g_bad_width
      $error("prescaler too narrow");
   end

   logic [PS_W-1:0] div_r;
   logic ext_prev_r;
   logic [PS_W:0] div_nxt;

   // ------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------
   assign div_nxt = {1'b0, div_r} + 1'b1;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt[PS_W-1:0];
      end
   end

   // Previous pin level for edge detection
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ext_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= ext_pin_i;
      end
   end

   function automatic logic tap(input logic [PS_W-1:0] d, input logic [3:0] lg);
      logic [PS_W-1:0] m;
      m = '0;
      m = (PS_W'(1) << lg) - PS_W'(1);
      tap = ((d & m) == m);
   endfunction

   // RQ5 source and edge select
   always_comb begin
      case (clk_sel_i)
         3'h1: tick_o = 1'b1;
         3'h2: tick_o = tap(div_r, tmr16_pkg::PS_8);
         3'h3: tick_o = tap(div_r, tmr16_pkg::PS_64);
         3'h4: tick_o = tap(div_r, tmr16_pkg::PS_256);
         3'h5: tick_o = tap(div_r, tmr16_pkg::PS_1024);
         3'h6: tick_o = ext_prev_r & ~ext_pin_i;
         3'h7: tick_o = ~ext_prev_r & ext_pin_i;
         // RQ6 no source, no tick
         default: tick_o = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// file: hdl/tmr16_core.sv
// 16-bit timer/counter core with compare, capture and byte access port
//
// Overview of operation
// RQ1: Counter, compares, capture are 16 bits, reached via two-step byte access.
// RQ2: Both control registers are 8 bits, read and written in one access.
// RQ3: Every request shows in the flag register, gated by its own mask bit.
// RQ4: Four sources: overflow, match A, match B, input capture.
// RQ5: Tick comes from prescaler or event pin, with selectable edge.
// RQ6: With no clock source the counter holds still.
// RQ7: Buffered compares checked every tick and drive waveform pins.
// RQ8: A compare match sets that channel's match flag.
// RQ9: Selected edge on capture pin or comparator loads counter into capture.
// RQ10: Optional filter suppresses short spikes before capture edge detection.
// RQ11: TOP is 0x00ff, 0x01ff, 0x03ff, compare A or capture per mode.
// RQ12: Compare A as PWM TOP gives no A output; TOP is double buffered.
// RQ13: Capture register may serve as fixed TOP, freeing compare A.
// RQ14: Bottom indication when counter becomes 0x0000.
// RQ15: Maximum indication when counter becomes 0xffff.
// RQ16: Timer works only while the power-off bit is zero.
// RQ17: CTC reload, phase-correct PWM, frequency generation, event counting.
// RQ18: High byte goes via shared temp; low write commits, low read latches.
// RQ19: CPU writes high byte first and reads low byte first.
// RQ20: CPU counter write beats clear or count in the same cycle.
// RQ21: Counter cleared, incremented or decremented per mode; always CPU accessible.
// RQ22: All registers reset to zero; timer stopped, interrupts masked.
`timescale 1ns/100ps
`default_nettype none
module tmr16_core #(
   parameter int unsigned FILT = tmr16_pkg::FILT_LEN
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire tmr16_pkg::tmr16_bus_t bus_i,
   output logic [7:0] rdata_o,
   input wire logic timer_power_off_bit_i,
   input wire logic event_count_pin_i,
   input wire logic capture_pin_i,
   input wire logic comparator_i,
   input wire logic cap_from_comp_i,
   input wire logic [3:0] irq_ack_i,
   output logic [3:0] irq_o,
   output logic wave_out_a_o,
   output logic wave_out_b_o,
   output logic bottom_o,
   output logic max_o
);
   if (FILT < 2 || FILT > 8) begin : g_bad_filt
      $error("filter length out of range");
   end

   logic [15:0] count_value_r, compare_a_value_r, compare_b_value_r, capture_value_r;
   logic [15:0] cmpa_buf_r, cmpb_buf_r;
   logic [7:0] temp_r, control_a, control_b;
   logic [3:0] timer_flag_reg, timer_mask_reg;
   logic down_r;
   logic [FILT-1:0] filt_sh_r;
   logic cap_lvl_r, cap_prev_r;
   logic timer_tick, tick_raw;
   logic [3:0] wgm;
   logic [15:0] top;
   logic pwm_mode, phase_mode, buf_at_top, at_top, at_bottom;
   logic cnt_wr, match_a, match_b, cap_evt, cap_src, ovf_evt;
   logic [3:0] set_ev;

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   assign wgm = {control_b[tmr16_pkg::CB_WGM_HI +: 2], control_a[tmr16_pkg::CA_WGM_LO +: 2]};
   // RQ17 mode classes
   assign pwm_mode = (wgm != 4'h0) && (wgm != 4'h4) && (wgm != 4'hc);
   assign phase_mode = pwm_mode && (wgm[3:2] == 2'b10 || wgm[1:0] != 2'b00 && wgm[3:2] == 2'b00
                       || wgm == 4'hb || wgm == 4'ha);
   assign buf_at_top = phase_mode;

   // RQ11 top select
   always_comb begin
      case (wgm)
         4'h1, 4'h5: top = tmr16_pkg::TOP_8BIT;
         4'h2, 4'h6: top = tmr16_pkg::TOP_9BIT;
         4'h3, 4'h7: top = tmr16_pkg::TOP_10BIT;
         4'h4, 4'h9, 4'hb, 4'hf: top = cmpa_buf_r;
         // RQ13 capture as top
         4'h8, 4'ha, 4'hc, 4'he: top = capture_value_r;
         default: top = tmr16_pkg::MAX_VAL;
      endcase
   end

   assign at_top = (count_value_r == top);
   assign at_bottom = (count_value_r == tmr16_pkg::BOTTOM_VAL);
   // RQ16 gated by power-off bit
   assign timer_tick = tick_raw & ~timer_power_off_bit_i;
   assign cnt_wr = bus_i.wr && bus_i.sel == tmr16_pkg::REG_CNT_LO;

   tmr16_tick_gen #(.PS_W(10)) u_tick (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .clk_sel_i(control_b[tmr16_pkg::CB_CS_LO +: 3]),
      .ext_pin_i(event_count_pin_i),
      .tick_o(tick_raw)
   );

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   // RQ22 zero at reset
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_value_r <= tmr16_pkg::CNT_RST;
         down_r <= 1'b0;
      end else if (cnt_wr) begin
         // RQ20 CPU write wins
         count_value_r <= {temp_r, bus_i.wdata};
      end else if (timer_tick) begin
         // RQ21 clear, up or down
         if (phase_mode) begin
            if (at_top || (down_r && !at_bottom)) begin
               count_value_r <= count_value_r - 16'h0001;
               down_r <= 1'b1;
            end else begin
               count_value_r <= count_value_r + 16'h0001;
               down_r <= 1'b0;
            end
         end else if (at_top) begin
            count_value_r <= tmr16_pkg::BOTTOM_VAL;
         end else begin
            count_value_r <= count_value_r + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // Compare buffers
   // ------------------------------------------------------------
   // RQ12 double buffered top and compares
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmpa_buf_r <= tmr16_pkg::CNT_RST;
         cmpb_buf_r <= tmr16_pkg::CNT_RST;
      end else if (!pwm_mode || (timer_tick && (buf_at_top ? at_top : at_bottom))) begin
         cmpa_buf_r <= compare_a_value_r;
         cmpb_buf_r <= compare_b_value_r;
      end
   end

   // RQ7 compare every tick
   assign match_a = timer_tick && !cnt_wr && count_value_r == cmpa_buf_r;
   assign match_b = timer_tick && !cnt_wr && count_value_r == cmpb_buf_r;
   assign ovf_evt = timer_tick && !cnt_wr && (phase_mode ? at_bottom && down_r : at_top || count_value_r ==
                    tmr16_pkg::MAX_VAL);

   // Waveform generators: toggle, clear or set on match in non-PWM, set/clear in PWM
   function automatic logic wave(input logic cur, input logic [1:0] com, input logic m, input logic pwm,
                                 input logic dn, input logic bot);
      logic nv;
      nv = cur;
      if (!pwm) begin
         if (m && com == 2'b01) nv = ~cur;
         if (m && com == 2'b10) nv = 1'b0;
         if (m && com == 2'b11) nv = 1'b1;
      end else if (com[1]) begin
         if (m) nv = com[0] ^ ~dn;
         else if (bot) nv = ~com[0];
      end
      wave = nv;
   endfunction

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wave_out_a_o <= 1'b0;
         wave_out_b_o <= 1'b0;
      end else begin
         // RQ12 no A output when compare A is PWM top (modes 9, b, f)
         // Decode the mode, not the value: a fixed TOP equal to compare A must not mute the pin
         if (!(pwm_mode && (wgm == 4'h9 || wgm == 4'hb || wgm == 4'hf)))
            wave_out_a_o <= wave(wave_out_a_o, control_a[tmr16_pkg::CA_COMA_LO +: 2], match_a, pwm_mode,
                                 down_r, timer_tick && at_bottom && !phase_mode);
         wave_out_b_o <= wave(wave_out_b_o, control_a[tmr16_pkg::CA_COMB_LO +: 2], match_b, pwm_mode,
                              down_r, timer_tick && at_bottom && !phase_mode);
      end
   end

   // ------------------------------------------------------------
   // Capture path
   // ------------------------------------------------------------
   assign cap_src = cap_from_comp_i ? comparator_i : capture_pin_i;
   // RQ10 spike filter
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         filt_sh_r <= '0;
         cap_lvl_r <= 1'b0;
         cap_prev_r <= 1'b0;
      end else begin
         filt_sh_r <= {filt_sh_r[FILT-2:0], cap_src};
         if (!control_b[tmr16_pkg::CB_CAP_FILT]) cap_lvl_r <= cap_src;
         else if (&filt_sh_r) cap_lvl_r <= 1'b1;
         else if (~|filt_sh_r) cap_lvl_r <= 1'b0;
         cap_prev_r <= cap_lvl_r;
      end
   end

   // RQ9 edge select
   assign cap_evt = ~timer_power_off_bit_i && (control_b[tmr16_pkg::CB_CAP_EDGE] ? (cap_lvl_r & ~cap_prev_r)
                    : (~cap_lvl_r & cap_prev_r));

   // ------------------------------------------------------------
   // CPU-written registers
   // ------------------------------------------------------------
   // RQ18 temp latches high byte on write, counter or capture high on its own low read
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         temp_r <= tmr16_pkg::CTRL_RST;
      end else if (bus_i.wr && (bus_i.sel == tmr16_pkg::REG_CNT_HI || bus_i.sel == tmr16_pkg::REG_CMPA_HI ||
                   bus_i.sel == tmr16_pkg::REG_CMPB_HI || bus_i.sel == tmr16_pkg::REG_CAP_HI)) begin
         temp_r <= bus_i.wdata;
      end else if (bus_i.rd && bus_i.sel == tmr16_pkg::REG_CNT_LO) begin
         temp_r <= count_value_r[15:8];
      end else if (bus_i.rd && bus_i.sel == tmr16_pkg::REG_CAP_LO) begin
         temp_r <= capture_value_r[15:8];
      end
   end

   // RQ1 commit on low byte write
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         compare_a_value_r <= tmr16_pkg::CNT_RST;
         compare_b_value_r <= tmr16_pkg::CNT_RST;
         capture_value_r <= tmr16_pkg::CNT_RST;
      end else begin
         if (bus_i.wr && bus_i.sel == tmr16_pkg::REG_CMPA_LO) compare_a_value_r <= {temp_r, bus_i.wdata};
         if (bus_i.wr && bus_i.sel == tmr16_pkg::REG_CMPB_LO) compare_b_value_r <= {temp_r, bus_i.wdata};
         if (bus_i.wr && bus_i.sel == tmr16_pkg::REG_CAP_LO) capture_value_r <= {temp_r, bus_i.wdata};
         else if (cap_evt) capture_value_r <= count_value_r;
      end
   end

   // RQ2 single access control
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         control_a <= tmr16_pkg::CTRL_RST;
         control_b <= tmr16_pkg::CTRL_RST;
         timer_mask_reg <= tmr16_pkg::IRQ_RST;
      end else begin
         if (bus_i.wr && bus_i.sel == tmr16_pkg::REG_CTRL_A) control_a <= bus_i.wdata;
         if (bus_i.wr && bus_i.sel == tmr16_pkg::REG_CTRL_B) control_b <= bus_i.wdata;
         if (bus_i.wr && bus_i.sel == tmr16_pkg::REG_MASK) timer_mask_reg <= bus_i.wdata[3:0];
      end
   end

   // ------------------------------------------------------------
   // Flags and requests
   // ------------------------------------------------------------
   always_comb begin
      set_ev = '0;
      set_ev[tmr16_pkg::IRQ_OVF] = ovf_evt;
      // RQ8 match sets flag
      set_ev[tmr16_pkg::IRQ_MA] = match_a;
      set_ev[tmr16_pkg::IRQ_MB] = match_b;
      set_ev[tmr16_pkg::IRQ_CAP] = cap_evt;
   end

   // RQ4 four sticky flags; set beats write-one clear or ack
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timer_flag_reg <= tmr16_pkg::IRQ_RST;
      end else begin
         timer_flag_reg <= (timer_flag_reg & ~(irq_ack_i | ((bus_i.wr && bus_i.sel == tmr16_pkg::REG_FLAG)
                           ? bus_i.wdata[3:0] : 4'h0))) | set_ev;
      end
   end

   // RQ3 per-bit masking; RQ14 RQ15 indications
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= tmr16_pkg::IRQ_RST;
         bottom_o <= 1'b0;
         max_o <= 1'b0;
      end else begin
         irq_o <= timer_flag_reg & timer_mask_reg;
         bottom_o <= at_bottom;
         max_o <= (count_value_r == tmr16_pkg::MAX_VAL);
      end
   end

   // Read mux, registered; compare reads bypass temp
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
      end else if (bus_i.rd) begin
         case (bus_i.sel)
            tmr16_pkg::REG_CNT_LO: rdata_o <= count_value_r[7:0];
            tmr16_pkg::REG_CMPA_LO: rdata_o <= compare_a_value_r[7:0];
            tmr16_pkg::REG_CMPA_HI: rdata_o <= compare_a_value_r[15:8];
            tmr16_pkg::REG_CMPB_LO: rdata_o <= compare_b_value_r[7:0];
            tmr16_pkg::REG_CMPB_HI: rdata_o <= compare_b_value_r[15:8];
            tmr16_pkg::REG_CAP_LO: rdata_o <= capture_value_r[7:0];
            tmr16_pkg::REG_CNT_HI, tmr16_pkg::REG_CAP_HI: rdata_o <= temp_r;
            tmr16_pkg::REG_CTRL_A: rdata_o <= control_a;
            tmr16_pkg::REG_CTRL_B: rdata_o <= control_b;
            tmr16_pkg::REG_FLAG: rdata_o <= {4'h0, timer_flag_reg};
            tmr16_pkg::REG_MASK: rdata_o <= {4'h0, timer_mask_reg};
            default: rdata_o <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_cnt_write;
      @(posedge clk_sys_i) disable iff (!rst_b_i) cnt_wr |=> count_value_r == $past({temp_r, bus_i.wdata});
   endproperty
   a_cnt_write: assert property (p_cnt_write) else $error("counter write lost"); // RQ20

   property p_stopped;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         (control_b[tmr16_pkg::CB_CS_LO +: 3] == 3'h0 && !cnt_wr) |=> $stable(count_value_r);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved with no source"); // RQ6

   property p_power;
      @(posedge clk_sys_i) disable iff (!rst_b_i) (timer_power_off_bit_i && !cnt_wr) |=> $stable(count_value_r);
   endproperty
   a_power: assert property (p_power) else $error("counter moved while powered off"); // RQ16

   property p_flag_a;
      @(posedge clk_sys_i) disable iff (!rst_b_i) match_a |=> timer_flag_reg[tmr16_pkg::IRQ_MA];
   endproperty
   a_flag_a: assert property (p_flag_a) else $error("match A flag not set"); // RQ8

   property p_irq;
      @(posedge clk_sys_i) disable iff (!rst_b_i) 1'b1 |=> irq_o == $past(timer_flag_reg & timer_mask_reg);
   endproperty
   a_irq: assert property (p_irq) else $error("request not gated by mask"); // RQ3

   property p_capture;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         (cap_evt && !(bus_i.wr && bus_i.sel == tmr16_pkg::REG_CAP_LO)) |=> capture_value_r == $past(count_value_r);
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed"); // RQ9

   property p_bottom;
      @(posedge clk_sys_i) disable iff (!rst_b_i) (count_value_r == tmr16_pkg::BOTTOM_VAL) |=> bottom_o;
   endproperty
   a_bottom: assert property (p_bottom) else $error("bottom indication missing"); // RQ14

   property p_max;
      @(posedge clk_sys_i) disable iff (!rst_b_i) (count_value_r == tmr16_pkg::MAX_VAL) |=> max_o;
   endproperty
   a_max: assert property (p_max) else $error("max indication missing"); // RQ15

   sequence s_low_read;
      bus_i.rd && bus_i.sel == tmr16_pkg::REG_CNT_LO && !bus_i.wr;
   endsequence
   property p_temp;
      @(posedge clk_sys_i) disable iff (!rst_b_i) s_low_read |=> temp_r == $past(count_value_r[15:8]);
   endproperty
   a_temp: assert property (p_temp) else $error("temp not loaded on low read"); // RQ18
endmodule
`default_nettype wire

// file: dv/tmr16_pins_model.sv
// Pin-side partner model: event count, capture and comparator sources
`timescale 1ns/100ps
`default_nettype none
module tmr16_pins_model (
   input wire logic clk_sys_i,
   output logic event_count_pin_o,
   output logic capture_pin_o,
   output logic comparator_o
);
   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   // Pins idle low between events
   initial begin
      event_count_pin_o = 1'b0;
      capture_pin_o = 1'b0;
      comparator_o = 1'b0;
   end

   // slow clean pulses
   // Four cycles high and five low per pulse so the edge detector sees every level
   task automatic evt(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         event_count_pin_o <= 1'b1;
         repeat (4) @(posedge clk_sys_i);
         event_count_pin_o <= 1'b0;
         repeat (4) @(posedge clk_sys_i);
      end
   endtask

   // capture source pulse
   // Short pulses stand in for noise spikes
   task automatic cap(input logic comp, input int len);
      @(posedge clk_sys_i);
      comparator_o <= comp;
      capture_pin_o <= !comp;
      repeat (len) @(posedge clk_sys_i);
      comparator_o <= 1'b0;
      capture_pin_o <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
   endtask
endmodule
`default_nettype wire

// file: dv/tmr16_core_tb.sv
// Self-checking testbench of the 16-bit timer core
`timescale 1ns/100ps
`default_nettype none
module tmr16_core_tb;
   localparam int CNT = tmr16_pkg::REG_CNT_LO;
   localparam int CMPA = tmr16_pkg::REG_CMPA_LO;
   localparam int CMPB = tmr16_pkg::REG_CMPB_LO;
   localparam int CAP = tmr16_pkg::REG_CAP_LO;
   localparam int CA = tmr16_pkg::REG_CTRL_A;
   localparam int CB = tmr16_pkg::REG_CTRL_B;
   localparam int FLG = tmr16_pkg::REG_FLAG;
   localparam int MSK = tmr16_pkg::REG_MASK;
   logic clk_sys_i, rst_b_i, power_off, cap_sel, evt_pin, cap_pin, comp;
   logic wave_a, wave_b, bot, mx, sm, sb;
   tmr16_pkg::tmr16_bus_t bus;
   logic [3:0] ack, irq;
   logic [7:0] rdata, rv;
   logic [15:0] v;
   logic [3:0] wg [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'hc};
   logic [15:0] tp [5] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'h0030, 16'h0040};
   int error_cnt = 0;
   int samples_checked = 0;

   tmr16_core dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata),
      .timer_power_off_bit_i(power_off), .event_count_pin_i(evt_pin), .capture_pin_i(cap_pin),
      .comparator_i(comp), .cap_from_comp_i(cap_sel), .irq_ack_i(ack), .irq_o(irq),
      .wave_out_a_o(wave_a), .wave_out_b_o(wave_b), .bottom_o(bot), .max_o(mx));
   tmr16_pins_model pins (.clk_sys_i(clk_sys_i), .event_count_pin_o(evt_pin),
      .capture_pin_o(cap_pin), .comparator_o(comp));

   // 125 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   // One byte access; read data is taken once the registered answer lands
   task automatic acc(input logic w, input int s, input logic [7:0] d);
      @(posedge clk_sys_i);
      bus <= '{wr: w, rd: !w, sel: tmr16_pkg::tmr16_reg_t'(s), wdata: d};
      @(posedge clk_sys_i);
      bus <= '0;
      // rdata_o stands until the next read; taking it one edge later keeps all driving on edges
      @(posedge clk_sys_i);
      rv = rdata;
   endtask

   task automatic wr16(input int s, input logic [15:0] x);
      acc(1'b1, s + 1, x[15:8]);
      acc(1'b1, s, x[7:0]);
   endtask

   task automatic rd16(input int s);
      acc(1'b0, s, 8'h00);
      v[7:0] = rv;
      acc(1'b0, s + 1, 8'h00);
      v[15:8] = rv;
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_basic;
      for (int s = 0; s < 12; s++) begin
         acc(1'b0, s, 8'h00);
         chk("reset reg", 16'h0, {8'h0, rv});
      end
      wr16(CNT, 16'h1234);
      repeat (20) @(posedge clk_sys_i);
      rd16(CNT);
      chk("stopped count", 16'h1234, v);
      acc(1'b1, CA, 8'h50);
      acc(1'b0, CA, 8'h00);
      chk("control_a", 16'h0050, {8'h0, rv});
   endtask

   task automatic t_events;
      wr16(CNT, 16'h0000);
      acc(1'b1, CB, 8'h07);
      pins.evt(5);
      acc(1'b1, CB, 8'h06);
      pins.evt(3);
      acc(1'b1, CB, 8'h00);
      rd16(CNT);
      chk("event count", 16'h0008, v);
   endtask

   task automatic t_power;
      power_off <= 1'b1;
      wr16(CNT, 16'h0050);
      acc(1'b1, CB, 8'h01);
      repeat (30) @(posedge clk_sys_i);
      acc(1'b1, CB, 8'h00);
      power_off <= 1'b0;
      rd16(CNT);
      chk("power off count", 16'h0050, v);
      acc(1'b1, CB, 8'h01);
      wr16(CNT, 16'h0a00);
      rd16(CNT);
      acc(1'b1, CB, 8'h00);
      chk("write beats count", 16'h1, {15'h0, (v - 16'h0a00) < 16'h8});
   endtask

   task automatic t_ovf;
      sm = 1'b0;
      sb = 1'b0;
      acc(1'b1, MSK, 8'h01);
      wr16(CNT, 16'hfff0);
      acc(1'b1, CB, 8'h01);
      // Bounded wait; max and bottom each stand one cycle as the count wraps
      for (int n = 0; n < 100 && irq[0] !== 1'b1; n++) begin
         @(posedge clk_sys_i);
         sm = sm | (mx === 1'b1);
         sb = sb | (bot === 1'b1);
      end
      acc(1'b1, CB, 8'h00);
      chk("overflow irq", 16'h1, {15'h0, irq[0]});
      chk("max seen", 16'h1, {15'h0, sm});
      chk("bottom seen", 16'h1, {15'h0, sb});
      acc(1'b1, FLG, 8'h0f);
      acc(1'b0, FLG, 8'h00);
      chk("flags cleared", 16'h0, {8'h0, rv});
      chk("irq cleared", 16'h0, {12'h0, irq});
   endtask

   task automatic t_cmp;
      acc(1'b1, CA, 8'h50);
      wr16(CMPA, 16'h0100);
      wr16(CMPB, 16'h0108);
      wr16(CNT, 16'h00f0);
      acc(1'b1, FLG, 8'h0f);
      acc(1'b1, MSK, 8'h02);
      acc(1'b1, CB, 8'h01);
      repeat (60) @(posedge clk_sys_i);
      acc(1'b1, CB, 8'h00);
      acc(1'b0, FLG, 8'h00);
      chk("match flags", 16'h0006, {8'h0, rv});
      chk("masked irq", 16'h0002, {12'h0, irq});
      chk("wave a toggled", 16'h1, {15'h0, wave_a});
      chk("wave b toggled", 16'h1, {15'h0, wave_b});
      ack <= 4'h2;
      @(posedge clk_sys_i);
      ack <= 4'h0;
      repeat (3) @(posedge clk_sys_i);
      chk("acked irq", 16'h0, {12'h0, irq});
   endtask

   task automatic t_cap;
      acc(1'b1, MSK, 8'h00);
      wr16(CNT, 16'h4321);
      acc(1'b1, FLG, 8'h0f);
      acc(1'b1, CB, 8'hc0);
      pins.cap(1'b0, 2);
      acc(1'b0, FLG, 8'h00);
      chk("spike ignored", 16'h0, {15'h0, rv[3]});
      pins.cap(1'b0, 10);
      acc(1'b0, FLG, 8'h00);
      chk("capture flag", 16'h1, {15'h0, rv[3]});
      rd16(CAP);
      chk("capture pin", 16'h4321, v);
      cap_sel <= 1'b1;
      wr16(CNT, 16'h0777);
      pins.cap(1'b1, 10);
      rd16(CAP);
      chk("capture comp", 16'h0777, v);
      cap_sel <= 1'b0;
   endtask

   // Start a few counts below each TOP; the count must wrap or turn there
   task automatic t_top;
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, CB, {3'h0, wg[i][3:2], 3'h0});
         acc(1'b1, CA, {6'h0, wg[i][1:0]});
         wr16(CMPA, 16'h0030);
         wr16(CAP, 16'h0040);
         wr16(CNT, tp[i] - 16'h0004);
         acc(1'b1, CB, {3'h0, wg[i][3:2], 3'h1});
         repeat (40) @(posedge clk_sys_i);
         acc(1'b1, CB, 8'h00);
         rd16(CNT);
         chk("count within top", 16'h1, {15'h0, v <= tp[i]});
      end
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      rst_b_i = 1'b0;
      power_off = 1'b0;
      cap_sel = 1'b0;
      ack = 4'h0;
      bus = '0;
      repeat (16) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      t_basic();
      t_events();
      t_power();
      t_ovf();
      t_cmp();
      t_cap();
      t_top();
      wrap_up();
   end

   // The sequence needs under a thousand cycles; this cuts a hang short
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      error_cnt++;
      $display("wrong value watchdog expected done seen hang");
      wrap_up();
   end
endmodule
`default_nettype wire
